//--- src/asp_top.sv
// Purpose: Register block, transmitter and receiver of the async serial port
// Assumes: One clock, synchronous reset, rx pin asynchronous to the clock
// Notes: TICK_DIV clock cycles make one sixteenth of a bit
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module asp_top #(
  parameter int TICK_DIV = asp_pkg::TICK_DIV_DEF
) (
  input wire logic clk_sys_in, // 40 MHz system clock
  input wire logic sys_rst_in, // Synchronous reset, high
  input wire logic [asp_pkg::ADDR_W-1:0] addr_in, // Register address
  input wire logic [7:0] wr_data_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  output wire logic [7:0] rd_data_out, // Read data, cycle after strobe
  input wire logic rx_pin_in, // Serial receive pin
  output wire logic tx_pin_out, // Serial transmit pin
  output wire logic tx_oe_out, // Transmit pin driven
  output wire logic irq_out // Serial interrupt request
);
  import asp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [15:0] tick_cnt;
    logic tx_r8;
    logic len9;
    logic rouse;
    logic [7:0] ctl2;
    logic tx_buffer_empty;
    logic tc;
    logic rx_buffer_full;
    logic idle;
    logic ovr;
    logic nf;
    logic fe;
    logic [6:0] arm;
    logic [7:0] rx_data;
    logic rx_r8;
    logic [7:0] tx_data;
    asp_tx_state_t tx_state;
    logic [10:0] tx_shift;
    logic [3:0] tx_len;
    logic [3:0] tx_bits;
    logic [3:0] tx_sub;
    logic pre_pend;
    logic was_break;
    logic te_prev;
    logic tx_pin;
    logic tx_oe;
    logic rx_s1;
    logic rx_s2;
    asp_rx_state_t rx_state;
    logic [3:0] rx_sub;
    logic [3:0] rx_bits;
    logic [9:0] rx_shift;
    logic [1:0] rx_vote;
    logic rx_noise;
    logic [7:0] idle_cnt;
    logic idle_armed;
    logic irq;
    logic [7:0] rd_data;
  } asp_state_t;

  asp_state_t st;
  asp_state_t next_st;
  logic tick;
  logic rx_deliver;

  // Frame length in bits for the selected character length
  function automatic logic [3:0] frame_len(input logic len9);
    frame_len = len9 ? FRAME_LEN9 : FRAME_LEN8;
  endfunction : frame_len

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [3:0] flen;
    logic tx_en;
    logic te_rise;
    logic frame_end;
    logic tx_free;
    logic line;
    logic [1:0] v;
    logic bitv;
    logic [9:0] full;
    logic wake;
    logic [7:0] idle_tgt;
    next_st = st;
    flen = frame_len(st.len9);
    tx_en = st.ctl2[C2_TX_EN];
    te_rise = tx_en && !st.te_prev;
    line = st.rx_s2;
    v = 2'h0;
    bitv = 1'b0;
    full = 10'h000;
    wake = 1'b0;
    idle_tgt = {flen, 4'h0};
    rx_deliver = 1'b0;
    tick = (st.tick_cnt == 16'(TICK_DIV - 1));
    // Sample tick divider
    next_st.tick_cnt = tick ? 16'h0000 : st.tick_cnt + 16'h0001;
    next_st.rd_data = 8'h00;

    // Register writes; clears come first so hardware sets win
    if (wr_in) begin
      case (addr_in)
        OFS_CTL1: begin
          next_st.tx_r8 = wr_data_in[C1_TX_NINTH];
          next_st.len9 = wr_data_in[C1_LEN_SEL];
          next_st.rouse = wr_data_in[C1_ROUSE];
        end
        OFS_CTL2: begin
          next_st.ctl2 = wr_data_in;
        end
        OFS_DATA: begin
          next_st.tx_data = wr_data_in;
          if (st.arm[6]) begin
            next_st.tx_buffer_empty = 1'b0;
          end
          if (st.arm[5]) begin
            next_st.tc = 1'b0;
          end
          next_st.arm[6:5] = 2'b00;
        end
        default: begin
        end
      endcase
    end

    // Register reads and the read half of the clear sequences
    if (rd_in) begin
      case (addr_in)
        OFS_CTL1: begin
          next_st.rd_data = {st.rx_r8, st.tx_r8, 1'b0, st.len9, st.rouse, 3'b000};
        end
        OFS_CTL2: begin
          next_st.rd_data = st.ctl2;
        end
        OFS_FLAGS: begin
          next_st.rd_data = {st.tx_buffer_empty, st.tc, st.rx_buffer_full, st.idle, st.ovr, st.nf, st.fe, 1'b0};
          next_st.arm = {st.tx_buffer_empty, st.tc, st.rx_buffer_full, st.idle, st.ovr, 2'b11};
        end
        OFS_DATA: begin
          next_st.rd_data = st.rx_data;
          if (st.arm[4]) begin
            next_st.rx_buffer_full = 1'b0;
          end
          if (st.arm[3]) begin
            next_st.idle = 1'b0;
          end
          if (st.arm[2]) begin
            next_st.ovr = 1'b0;
          end
          if (st.arm[1]) begin
            next_st.nf = 1'b0;
          end
          if (st.arm[0]) begin
            next_st.fe = 1'b0;
          end
          next_st.arm[4:0] = 5'h00;
        end
        default: begin
          next_st.rd_data = 8'h00;
        end
      endcase
    end

    // Transmitter: frame sequencing
    frame_end = tick && (st.tx_sub == SUB_LAST) && (st.tx_bits == st.tx_len - 4'h1);
    tx_free = (st.tx_state == TX_IDLE) || frame_end;
    if (tx_free) begin
      next_st.tx_sub = 4'h0;
      next_st.tx_bits = 4'h0;
      if (tx_en && (te_rise || st.pre_pend)) begin
        next_st.tx_state = TX_PRE;
        next_st.tx_shift = 11'h7ff;
        next_st.tx_len = flen;
        next_st.pre_pend = 1'b0;
      end else if (tx_en && st.ctl2[C2_BREAK]) begin
        next_st.tx_state = TX_BREAK;
        next_st.tx_shift = 11'h000;
        next_st.tx_len = flen;
        next_st.was_break = 1'b1;
      end else if (st.was_break) begin
        next_st.tx_state = TX_MARK;
        next_st.tx_shift = 11'h7ff;
        next_st.tx_len = MARK_LEN;
        next_st.was_break = 1'b0;
      end else if (tx_en && !next_st.tx_buffer_empty) begin
        next_st.tx_state = TX_DATA;
        next_st.tx_len = flen;
        next_st.tx_buffer_empty = 1'b1;
        // Stop bit high, start bit low
        if (st.len9) begin
          next_st.tx_shift = {1'b1, st.tx_r8, st.tx_data, 1'b0};
        end else begin
          next_st.tx_shift = {2'b11, st.tx_data, 1'b0};
        end
      end else begin
        next_st.tx_state = TX_IDLE;
      end
    end else if (tick) begin
      next_st.tx_sub = st.tx_sub + 4'h1;
      if (st.tx_sub == SUB_LAST) begin
        next_st.tx_bits = st.tx_bits + 4'h1;
        next_st.tx_shift = {1'b1, st.tx_shift[10:1]};
      end
    end
    if (te_rise && !tx_free) begin
      next_st.pre_pend = 1'b1;
    end
    next_st.te_prev = tx_en;
    // Done once the buffer is empty and nothing goes out
    if ((next_st.tx_state == TX_IDLE) && next_st.tx_buffer_empty) begin
      next_st.tc = 1'b1;
    end
    next_st.tx_pin = (next_st.tx_state == TX_IDLE) ? 1'b1 : next_st.tx_shift[0];
    next_st.tx_oe = tx_en || (next_st.tx_state != TX_IDLE);

    // Receiver: pin synchroniser
    next_st.rx_s1 = rx_pin_in;
    next_st.rx_s2 = st.rx_s1;

    // Receiver: bit recovery and delivery
    if (!st.ctl2[C2_RX_EN]) begin
      next_st.rx_state = RX_IDLE;
      next_st.idle_cnt = 8'h00;
    end else if (tick) begin
      case (st.rx_state)
        RX_IDLE: begin
          if (!line) begin
            next_st.rx_state = RX_BITS;
            next_st.rx_sub = 4'h1;
            next_st.rx_bits = 4'h0;
            next_st.rx_vote = 2'h0;
            next_st.rx_noise = 1'b0;
            next_st.idle_cnt = 8'h00;
            next_st.idle_armed = 1'b1;
          end else if (st.idle_cnt < idle_tgt) begin
            next_st.idle_cnt = st.idle_cnt + 8'h01;
            if ((next_st.idle_cnt == idle_tgt) && st.idle_armed) begin
              next_st.idle_armed = 1'b0;
              if (st.ctl2[C2_STANDBY]) begin
                if (!st.rouse) begin
                  next_st.ctl2[C2_STANDBY] = 1'b0;
                end
              end else begin
                next_st.idle = 1'b1;
              end
            end
          end
        end
        RX_BITS: begin
          next_st.rx_sub = st.rx_sub + 4'h1;
          v = st.rx_vote + {1'b0, line};
          if ((st.rx_sub == SAMPLE_A) || (st.rx_sub == SAMPLE_M)) begin
            next_st.rx_vote = v;
          end
          if (st.rx_sub == SUB_LAST) begin
            next_st.rx_bits = st.rx_bits + 4'h1;
            next_st.rx_vote = 2'h0;
          end
          if (st.rx_sub == SAMPLE_B) begin
            bitv = v[1];
            full = {bitv, st.rx_shift[9:1]};
            next_st.rx_noise = st.rx_noise || ((v != 2'h0) && (v != 2'h3));
            if (st.rx_bits == 4'h0) begin
              if (bitv) begin
                next_st.rx_state = RX_IDLE;
              end
            end else if (st.rx_bits == flen - 4'h1) begin
              next_st.rx_state = RX_IDLE;
              wake = st.ctl2[C2_STANDBY] && st.rouse && full[8];
              if (wake) begin
                next_st.ctl2[C2_STANDBY] = 1'b0;
              end
              if (!st.ctl2[C2_STANDBY] || wake) begin
                rx_deliver = 1'b1;
                // A data read clearing full in this cycle frees the buffer
                if (next_st.rx_buffer_full) begin
                  next_st.ovr = 1'b1;
                end else begin
                  next_st.rx_buffer_full = 1'b1;
                  next_st.nf = next_st.rx_noise;
                  next_st.fe = !bitv;
                  if (st.len9) begin
                    next_st.rx_data = full[7:0];
                    next_st.rx_r8 = full[8];
                  end else begin
                    next_st.rx_data = full[8:1];
                  end
                end
              end
            end else begin
              next_st.rx_shift = full;
            end
          end
        end
        default: begin
          next_st.rx_state = RX_IDLE;
        end
      endcase
    end

    // Single request from the four masked sources
    next_st.irq = (st.ctl2[C2_TX_EMPTY_IE] && st.tx_buffer_empty)
      || (st.ctl2[C2_TX_DONE_IE] && st.tc)
      || (st.ctl2[C2_RX_EN] && !st.ctl2[C2_STANDBY] && (
        (st.ctl2[C2_RX_FULL_IE] && (st.rx_buffer_full || st.ovr))
        || (st.ctl2[C2_IDLE_IE] && st.idle)));

    // Reset leaves data, ninth bits, length and wakeup untouched
    if (sys_rst_in) begin
      next_st.tick_cnt = 16'h0000;
      next_st.ctl2 = CTL2_RST;
      next_st.tx_buffer_empty = 1'b1;
      next_st.tc = 1'b1;
      next_st.rx_buffer_full = 1'b0;
      next_st.idle = 1'b0;
      next_st.ovr = 1'b0;
      next_st.nf = 1'b0;
      next_st.fe = 1'b0;
      next_st.arm = 7'h00;
      next_st.tx_state = TX_IDLE;
      next_st.tx_shift = 11'h7ff;
      next_st.tx_len = FRAME_LEN8;
      next_st.tx_bits = 4'h0;
      next_st.tx_sub = 4'h0;
      next_st.pre_pend = 1'b0;
      next_st.was_break = 1'b0;
      next_st.te_prev = 1'b0;
      next_st.tx_pin = 1'b1;
      next_st.tx_oe = 1'b0;
      next_st.rx_s1 = 1'b1;
      next_st.rx_s2 = 1'b1;
      next_st.rx_state = RX_IDLE;
      next_st.rx_sub = 4'h0;
      next_st.rx_bits = 4'h0;
      next_st.rx_shift = 10'h000;
      next_st.rx_vote = 2'h0;
      next_st.rx_noise = 1'b0;
      next_st.idle_cnt = 8'h00;
      next_st.idle_armed = 1'b0;
      next_st.irq = 1'b0;
      next_st.rd_data = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys_in) begin
    st <= next_st;
  end

  // Outputs straight from the state register
  assign rd_data_out = st.rd_data;
  assign tx_pin_out = st.tx_pin;
  assign tx_oe_out = st.tx_oe;
  assign irq_out = st.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_reset_flags;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      $fell(sys_rst_in) |-> (st.tx_buffer_empty && st.tc && !st.rx_buffer_full && !st.ovr && st.ctl2 == CTL2_RST);
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("flags wrong after reset");

  property p_empty_irq;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (st.tx_buffer_empty && st.ctl2[C2_TX_EMPTY_IE]) |=> irq_out;
  endproperty
  a_empty_irq: assert property (p_empty_irq) else $error("empty request missing");

  property p_irq_masked;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (st.ctl2[7:4] == 4'h0) |=> !irq_out;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("request with all masks off");

  property p_data_read;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (rd_in && addr_in == OFS_DATA) |=> (rd_data_out == $past(st.rx_data));
  endproperty
  a_data_read: assert property (p_data_read) else $error("data read mismatch");

  property p_overrun_keep;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (rx_deliver && st.rx_buffer_full && !(rd_in && addr_in == OFS_DATA && st.arm[4]))
        |=> (st.ovr && $stable(st.rx_data) && $stable(st.fe));
  endproperty
  a_overrun_keep: assert property (p_overrun_keep) else $error("overrun lost data");

  property p_break_low;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (st.tx_state == TX_BREAK) |-> !tx_pin_out;
  endproperty
  a_break_low: assert property (p_break_low) else $error("break not low");

  property p_pre_high;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (st.tx_state == TX_PRE) |-> (tx_pin_out && tx_oe_out);
  endproperty
  a_pre_high: assert property (p_pre_high) else $error("preamble not high");

  property p_te_start;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (st.ctl2[C2_TX_EN] && !st.te_prev && st.tx_state == TX_IDLE) |=> (st.tx_state == TX_PRE);
  endproperty
  a_te_start: assert property (p_te_start) else $error("no preamble on enable");

  property p_rx_off_flags;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (!st.ctl2[C2_RX_EN] && !rd_in) |=> ($stable(st.rx_buffer_full) && $stable(st.ovr));
  endproperty
  a_rx_off_flags: assert property (p_rx_off_flags) else $error("flags moved while off");
endmodule : asp_top
`default_nettype wire

//--- src/asp_pkg.sv
// How it works
// - One data address serves both directions
// - Ninth received bit captured with data
// - Ninth transmit bit loaded with data
// - Length bit selects nine or eight bits
// - Wakeup bit selects address mark or idle
// - Buffer empty plus mask raises request
// - Transmit done plus mask raises request
// - Full or overrun plus mask raises request if receiver on, not standby
// - Idle line plus mask raises request if receiver on, not standby
// - Enabling transmitter first sends all-ones preamble
// - Receiver enable gates reception, keeps flags
// - Standby ends on chosen wakeup condition
// - Break bit sends zero groups, then one
// - Empty flag set on load, cleared by sequence
// - Done flag set when transmitter goes quiet
// - Full flag set on receive, cleared by sequence
// - Idle flag after a frame of ones
// - Overrun keeps old character, drops new
// - Noise flag set on disagreeing samples
// - Bad stop bit flags fault unless overrun
// - Start bit zero, stop bit one framing
// - Sixteen samples per bit, vote three
//
// Purpose: Constants and types of the async serial port register block
// Assumes: Byte-wide register port at the printed offsets
// Notes: Baud generation reduced to one tick divider parameter
package asp_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTL1 = 8'h0e;
  localparam logic [7:0] OFS_CTL2 = 8'h0f;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_DATA = 8'h11;
  // Control one fields
  localparam int C1_RX_NINTH = 7;
  localparam int C1_TX_NINTH = 6;
  localparam int C1_LEN_SEL = 4;
  localparam int C1_ROUSE = 3;
  // Control two fields
  localparam int C2_TX_EMPTY_IE = 7;
  localparam int C2_TX_DONE_IE = 6;
  localparam int C2_RX_FULL_IE = 5;
  localparam int C2_IDLE_IE = 4;
  localparam int C2_TX_EN = 3;
  localparam int C2_RX_EN = 2;
  localparam int C2_STANDBY = 1;
  localparam int C2_BREAK = 0;
  localparam logic [7:0] CTL2_RST = 8'h00;
  // Frame timing
  localparam logic [3:0] FRAME_LEN8 = 4'ha;
  localparam logic [3:0] FRAME_LEN9 = 4'hb;
  localparam logic [3:0] MARK_LEN = 4'h1;
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_A = 4'h7;
  localparam logic [3:0] SAMPLE_M = 4'h8;
  localparam logic [3:0] SAMPLE_B = 4'h9;
  localparam int TICK_DIV_DEF = 13;
  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_BREAK, TX_MARK, TX_DATA} asp_tx_state_t;
  typedef enum logic {RX_IDLE, RX_BITS} asp_rx_state_t;
endpackage : asp_pkg

//--- sim/asp_far_end.sv
// Purpose: Remote async transceiver facing the serial port pins
// Assumes: Bit period of BIT_CLKS clocks, eight data bits heard
// Notes: Receive line idles high like a pulled-up wire
`timescale 1ns/10ps
`default_nettype none
module asp_far_end #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk_in, // Bench clock
  input wire logic line_in, // Device transmit pin
  input wire logic oe_in, // Device drives its pin
  output logic line_out, // Device receive pin
  output logic [7:0] byte_out, // Character heard
  output logic stb_out // Character heard strobe
);
  initial begin
    line_out = 1'b1;
    byte_out = 8'h00;
    stb_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Send one frame, zero start, lsb first, chosen stop level
  task automatic send_char(input logic [8:0] d, input int nbits, input logic stop_v);
    line_out <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_in);
    for (int i = 0; i < nbits; i++) begin
      line_out <= d[i];
      repeat (BIT_CLKS) @(posedge clk_in);
    end
    line_out <= stop_v;
    repeat (BIT_CLKS) @(posedge clk_in);
    // One idle cycle so a following frame never reassigns in the same step
    line_out <= 1'b1;
    @(posedge clk_in);
  endtask : send_char
  ////////////////////////////////////////////////////////////////////////////////
  // Hear device frames at mid bit, keep only good stop bits
  always begin
    @(posedge clk_in);
    if (oe_in && !line_in) begin
      repeat (BIT_CLKS / 2) @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge clk_in);
        byte_out[i] <= line_in;
      end
      repeat (BIT_CLKS) @(posedge clk_in);
      stb_out <= line_in;
      @(posedge clk_in);
      stb_out <= 1'b0;
    end
  end
endmodule : asp_far_end
`default_nettype wire

//--- sim/test_async_serial_port_registers.sv
// Purpose: Self-checking bench of the async serial port register block
// Assumes: TICK_DIV of 1, so one bit lasts 16 clocks
// Notes: Reads note expected data in a queue, a watcher compares
`timescale 1ns/10ps
`default_nettype none
module test_async_serial_port_registers;
  import asp_pkg::*;
  logic clk_sys_in, sys_rst_in, wr_in, rd_in, rd_q, rx_line;
  logic [7:0] addr_in, wr_data_in, rd_data_out, far_byte;
  logic tx_pin_out, tx_oe_out, irq_out, far_stb;
  logic [15:0] exp_rd[$];
  logic [7:0] exp_tx[$];
  int n_mismatch, n_tests, cyc;
  asp_top #(.TICK_DIV(1)) dut_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .rd_data_out(rd_data_out), .rx_pin_in(rx_line), .tx_pin_out(tx_pin_out),
    .tx_oe_out(tx_oe_out), .irq_out(irq_out));
  asp_far_end #(.BIT_CLKS(16)) far_u (.clk_in(clk_sys_in), .line_in(tx_pin_out),
    .oe_in(tx_oe_out), .line_out(rx_line), .byte_out(far_byte), .stb_out(far_stb));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 25 ns period
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // Bus cycles, one gap cycle after each strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    addr_in <= a;
    rd_in <= 1'b1;
    exp_rd.push_back({m, e});
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask : rd
  task automatic irq_is(input logic e);
    repeat (3) @(posedge clk_sys_in);
    check({7'h00, irq_out}, {7'h00, e});
  endtask : irq_is
  // Let the line idle, expect idle flag, clear it
  task automatic settle();
    repeat (200) @(posedge clk_sys_in);
    rd(OFS_FLAGS, 8'hd0, 8'hfe);
    rd(OFS_DATA, 8'h00, 8'h00);
    rd(OFS_FLAGS, 8'hc0, 8'hfe);
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////////
  // Watchers: read data the cycle after a read, characters heard far side
  always @(posedge clk_sys_in) rd_q <= rd_in;
  always @(negedge clk_sys_in) begin
    if (rd_q === 1'b1 && exp_rd.size() > 0) begin
      check(rd_data_out & exp_rd[0][15:8], exp_rd[0][7:0] & exp_rd[0][15:8]);
      void'(exp_rd.pop_front());
    end
    if (far_stb === 1'b1 && exp_tx.size() > 0) begin
      check(far_byte, exp_tx.pop_front());
    end
  end
  // Hang guard
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] d, r1, r2;
    int lows;
    sys_rst_in = 1'b1;
    addr_in = 8'h00;
    wr_data_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    rd_q = 1'b0;
    void'($urandom(1667));
    repeat (5) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    // Reset values and an unmapped place
    rd(OFS_CTL2, CTL2_RST, 8'hff);
    rd(OFS_FLAGS, 8'hc0, 8'hfe);
    rd(8'h20, 8'h00, 8'hff);
    wr(OFS_CTL1, 8'h00);
    rd(OFS_CTL1, 8'h00, 8'h7f);
    // Transmit masks against the set flags
    wr(OFS_CTL2, 8'h80);
    irq_is(1'b1);
    wr(OFS_CTL2, 8'h40);
    irq_is(1'b1);
    wr(OFS_CTL2, 8'h00);
    irq_is(1'b0);
    // Clear transmit flags, then send one byte after the preamble
    d = 8'($urandom);
    rd(OFS_FLAGS, 8'hc0, 8'hfe);
    wr(OFS_DATA, d);
    rd(OFS_FLAGS, 8'h00, 8'hfe);
    exp_tx.push_back(d);
    wr(OFS_CTL2, 8'h08);
    lows = 0;
    repeat (150) begin
      @(posedge clk_sys_in);
      if (tx_pin_out !== 1'b1) lows++;
    end
    check(8'(lows), 8'h00);
    repeat (220) @(posedge clk_sys_in);
    rd(OFS_FLAGS, 8'hc0, 8'hfe);
    // One received byte, then idle line with its mask
    wr(OFS_CTL2, 8'h04);
    r1 = 8'($urandom);
    far_u.send_char({1'b0, r1}, 8, 1'b1);
    repeat (2) @(posedge clk_sys_in);
    rd(OFS_FLAGS, 8'he0, 8'hfe);
    rd(OFS_DATA, r1, 8'hff);
    rd(OFS_FLAGS, 8'hc0, 8'hfe);
    repeat (200) @(posedge clk_sys_in);
    wr(OFS_CTL2, 8'h14);
    irq_is(1'b1);
    wr(OFS_CTL2, 8'h04);
    settle();
    // Overrun, second word also with a bad stop bit
    r1 = 8'($urandom);
    r2 = 8'($urandom);
    far_u.send_char({1'b0, r1}, 8, 1'b1);
    far_u.send_char({1'b0, r2}, 8, 1'b0);
    repeat (2) @(posedge clk_sys_in);
    rd(OFS_FLAGS, 8'he8, 8'hfe);
    wr(OFS_CTL2, 8'h24);
    irq_is(1'b1);
    rd(OFS_DATA, r1, 8'hff);
    irq_is(1'b0);
    wr(OFS_CTL2, 8'h04);
    settle();
    // Nine-bit address wakeup from standby
    wr(OFS_CTL1, 8'h18);
    wr(OFS_CTL2, 8'h06);
    r1 = 8'($urandom);
    r2 = 8'($urandom);
    far_u.send_char({1'b0, r1}, 9, 1'b1);
    repeat (2) @(posedge clk_sys_in);
    rd(OFS_FLAGS, 8'hc0, 8'hfe);
    far_u.send_char({1'b1, r2}, 9, 1'b1);
    repeat (2) @(posedge clk_sys_in);
    rd(OFS_FLAGS, 8'he0, 8'hfe);
    rd(OFS_CTL1, 8'h98, 8'hff);
    rd(OFS_CTL2, 8'h04, 8'hff);
    rd(OFS_DATA, r2, 8'hff);
    settle();
    // Framing fault kept while the receiver is off
    wr(OFS_CTL1, 8'h00);
    r1 = 8'($urandom);
    far_u.send_char({1'b0, r1}, 8, 1'b0);
    repeat (2) @(posedge clk_sys_in);
    rd(OFS_FLAGS, 8'he2, 8'hfe);
    wr(OFS_CTL2, 8'h00);
    rd(OFS_FLAGS, 8'he2, 8'hfe);
    rd(OFS_DATA, r1, 8'hff);
    // Break groups of zeros after the preamble
    wr(OFS_CTL2, 8'h09);
    lows = 0;
    repeat (480) begin
      @(posedge clk_sys_in);
      if (tx_pin_out === 1'b0) lows++;
    end
    check({7'h00, lows >= 300}, 8'h01);
    wr(OFS_CTL2, 8'h08);
    repeat (200) @(posedge clk_sys_in);
    check({7'h00, tx_pin_out}, 8'h01);
    check({7'h00, tx_oe_out}, 8'h01);
    repeat (2) @(posedge clk_sys_in);
    check(8'(exp_tx.size()), 8'h00);
    check(8'(exp_rd.size()), 8'h00);
    test_done();
  end
endmodule : test_async_serial_port_registers
`default_nettype wire
